// >>> logic/rlsc_defines.svh
/*
  Constants of the redriver link state control: timing counts at the
  system clock, register offsets, field positions and reset values.
  Assumes a 50 MHz clock and a 32-bit APB register bus.
*/
`ifndef RLSC_DEFINES_SVH
`define RLSC_DEFINES_SVH

// ==========================================================
// clock and timing
`define RLSC_CLK_NS 20
`define RLSC_DEB_MIN_MS 3
`define RLSC_DEB_MAX_MS 10
`define RLSC_DEB_CYC ((`RLSC_DEB_MIN_MS*1000000+`RLSC_CLK_NS-1)/`RLSC_CLK_NS)
`define RLSC_OVERLAP_US 4
`define RLSC_AUX_OFF_NS 7500
`define RLSC_AUX_OFF_CYC (`RLSC_AUX_OFF_NS/`RLSC_CLK_NS)
`define RLSC_AUX_ON_NS 3000
`define RLSC_AUX_ON_CYC (`RLSC_AUX_ON_NS/`RLSC_CLK_NS)
`define RLSC_RXDET_MS 12
`define RLSC_RXDET_CYC (`RLSC_RXDET_MS*1000000/`RLSC_CLK_NS)
`define RLSC_IDLE_ENTRY_NS 10
`define RLSC_IDLE_ENTRY_CYC ((`RLSC_IDLE_ENTRY_NS+`RLSC_CLK_NS-1)/`RLSC_CLK_NS)
`define RLSC_U1_EXIT_NS 6
`define RLSC_U1_EXIT_CYC ((`RLSC_U1_EXIT_NS+`RLSC_CLK_NS-1)/`RLSC_CLK_NS)
`define RLSC_U2_EXIT_US 10
`define RLSC_U2_EXIT_CYC (`RLSC_U2_EXIT_US*1000/`RLSC_CLK_NS)
`define RLSC_U1_TO_U2_US 100
`define RLSC_U1_TO_U2_CYC (`RLSC_U1_TO_U2_US*1000/`RLSC_CLK_NS)
`define RLSC_SHTDN_MS 1
`define RLSC_SHTDN_CYC (`RLSC_SHTDN_MS*1000000/`RLSC_CLK_NS)
`define RLSC_POR_MS 1
`define RLSC_POR_CYC (`RLSC_POR_MS*1000000/`RLSC_CLK_NS)
`define RLSC_POR_SETTLE_CYC 16

// ==========================================================
// registers
`define RLSC_OFS_CTRL 12'h000
`define RLSC_OFS_EQPROG 12'h004
`define RLSC_OFS_STATUS 12'h008
`define RLSC_CTRL_EQ_PROG_BIT 0
`define RLSC_CTRL_RST 1'h0
`define RLSC_EQPROG_RST 6'h00

`endif

// >>> logic/rlsc_link_ctrl.sv
/*
  Redriver link state control: pin debounce, mode decode, aux switch,
  receiver detect and USB link power states, equalizer select, APB
  registers. Assumes all line and pin inputs are asynchronous to i_clk.
*/
// The APB interface to the registers and the placing of the registers are this design's own decisions.
// Behaviour
// - falling display-enable and hot-plug accepted only after 3 ms low
// - aux switch opens within 7500 ns of debounced display-enable low
// - aux switch closes within 3000 ns of display-enable high
// - receiver detect repeats at most every 12 ms while disconnected
// - detected receiver enables receive termination and redriving
// - leaving U0 puts outputs in electrical idle after 10 ns
// - in U1, idle break forwards signalling after nominal 6 ns
// - in U2/U3, idle break forwards signalling after nominal 10 us
// - leaving shutdown reaches U2/U3 within nominal 1 ms
// - device active within 1 ms of power-up
// - each channel group gets its own equalizer setting
// - equalization off while low-frequency signalling detected
// - default USB-only until usb enable pulses high then low
// - enables and orientation pins decode the lane mode
`timescale 1ns/1ps
`include "rlsc_defines.svh"
module rlsc_link_ctrl import rlsc_pkg::*; #(
  parameter int DEB_CYC = `RLSC_DEB_CYC,
  parameter int RXDET_CYC = `RLSC_RXDET_CYC,
  parameter int SHTDN_CYC = `RLSC_SHTDN_CYC,
  parameter int U1U2_CYC = `RLSC_U1_TO_U2_CYC,
  parameter int POR_CYC = `RLSC_POR_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_display_enable_pin,
  input wire logic i_usb_enable_pin,
  input wire logic i_flip_pin,
  input wire logic i_hot_plug_input,
  input wire logic i_rx_detected,
  input wire logic i_elec_idle,
  input wire logic i_lfps_detected,
  input wire logic [1:0] i_host_path_eq_select,
  input wire logic [1:0] i_superspeed_path_eq_select,
  input wire logic [1:0] i_display_path_eq_select,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_active,
  output logic o_rxdet_start,
  output logic o_rx_term_en,
  output logic o_tx_elec_idle,
  output logic o_usb_lanes_en,
  output logic [3:0] o_dp_lane_en,
  output logic o_flip,
  output logic o_aux_switch_closed,
  output logic o_eq_en,
  output logic [5:0] o_eq_gain
);
  localparam int CW = 20;
  localparam int NS = 13;
  localparam int SETTLE = `RLSC_POR_SETTLE_CYC;
  localparam int IDLE_ENTRY = `RLSC_IDLE_ENTRY_CYC;
  localparam int U1_EXIT = `RLSC_U1_EXIT_CYC;
  localparam int U2_EXIT = `RLSC_U2_EXIT_CYC;

  // ==========================================================
  // input synchronisers
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;
  wire [NS-1:0] pins_w = {i_display_enable_pin, i_usb_enable_pin,
    i_flip_pin, i_hot_plug_input, i_rx_detected, i_elec_idle,
    i_lfps_detected, i_host_path_eq_select,
    i_superspeed_path_eq_select, i_display_path_eq_select};
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins_w;
      sync2_reg <= sync1_reg;
    end
  end
  wire disp_s = sync2_reg[12];
  wire usb_s = sync2_reg[11];
  wire flip_s = sync2_reg[10];
  wire hpd_s = sync2_reg[9];
  wire rx_s = sync2_reg[8];
  wire idle_s = sync2_reg[7];
  wire lfps_s = sync2_reg[6];
  wire [5:0] eq_pin_s = sync2_reg[5:0];

  // ==========================================================
  // falling-edge debounce, display enable and hot plug
  wire [1:0] deb_raw_w = {disp_s, hpd_s};
  logic [1:0] deb_reg;
  logic [CW-1:0] deb_cnt_reg [2];
  for (genvar g = 0; g < 2; g++) begin : g_deb
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        deb_reg[g] <= 1'b0;
        deb_cnt_reg[g] <= '0;
      end else if (deb_raw_w[g]) begin
        deb_reg[g] <= 1'b1;
        deb_cnt_reg[g] <= '0;
      end else if (deb_reg[g]) begin
        if (deb_cnt_reg[g] == CW'(DEB_CYC - 1)) begin
          deb_reg[g] <= 1'b0;
          deb_cnt_reg[g] <= '0;
        end else begin
          deb_cnt_reg[g] <= deb_cnt_reg[g] + CW'(1);
        end
      end
    end
  end
  wire disp_db = deb_reg[1];
  wire hpd_db = deb_reg[0];

  // ==========================================================
  // usb-only default after power-up
  logic usb_default_reg;
  logic usb_seen_reg;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      usb_default_reg <= 1'b1;
      usb_seen_reg <= 1'b0;
    end else begin
      usb_seen_reg <= usb_seen_reg | usb_s;
      if (usb_seen_reg && !usb_s) begin
        usb_default_reg <= 1'b0;
      end
    end
  end
  wire usb_eff = usb_s | usb_default_reg;

  // ==========================================================
  // mode decode
  wire rlsc_mode_t mode_w = rlsc_mode_t'({disp_db, usb_eff});
  wire [3:0] dp_mask_w = !hpd_db ? 4'h0 :
    (mode_w == M_DP4) ? 4'hF :
    (mode_w == M_USB_DP2) ? 4'h3 : 4'h0;
  wire usb_lanes_w = (mode_w == M_USB) || (mode_w == M_USB_DP2);

  // ==========================================================
  // registers and apb slave
  logic ctrl_reg;
  logic [5:0] eqprog_reg;
  wire hit_ctrl = i_paddr == `RLSC_OFS_CTRL;
  wire hit_eq = i_paddr == `RLSC_OFS_EQPROG;
  wire hit_stat = i_paddr == `RLSC_OFS_STATUS;
  wire hit_any = hit_ctrl | hit_eq | hit_stat;
  wire first_acc = i_psel & i_penable & !o_pready;
  wire commit_wr = i_psel & i_penable & o_pready & i_pwrite;
  rlsc_state_t state_reg;
  wire [31:0] status_w = {18'h0, lfps_s, o_usb_lanes_en, o_dp_lane_en,
    usb_default_reg, o_rx_term_en, o_aux_switch_closed, hpd_db,
    disp_db, state_reg};
  wire [31:0] rd_w = hit_ctrl ? {31'h0, ctrl_reg} :
    hit_eq ? {26'h0, eqprog_reg} :
    hit_stat ? status_w : 32'h0;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
      ctrl_reg <= `RLSC_CTRL_RST;
      eqprog_reg <= `RLSC_EQPROG_RST;
    end else begin
      o_pready <= first_acc;
      o_pslverr <= first_acc & !hit_any;
      o_prdata <= (first_acc && !i_pwrite) ? rd_w : 32'h0;
      if (commit_wr && hit_ctrl) begin
        ctrl_reg <= i_pwdata[`RLSC_CTRL_EQ_PROG_BIT];
      end
      if (commit_wr && hit_eq) begin
        eqprog_reg <= i_pwdata[5:0];
      end
    end
  end

  // ==========================================================
  // link power state machine
  rlsc_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [CW-1:0] lim_reg;
  logic [CW-1:0] lim_next;
  logic idle_next;
  logic term_next;
  logic rxdet_next;
  wire [CW-1:0] cnt_inc = cnt_reg + CW'(1);
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_inc;
    lim_next = lim_reg;
    idle_next = o_tx_elec_idle;
    term_next = o_rx_term_en;
    rxdet_next = 1'b0;
    if (state_reg != S_POR && !usb_eff) begin
      state_next = S_SHTDN;
      cnt_next = '0;
      idle_next = 1'b1;
      term_next = 1'b0;
    end else begin
      case (state_reg)
        S_POR: begin
          if (cnt_reg == CW'(SETTLE - 1)) begin
            state_next = S_DISC;
            cnt_next = '0;
          end
        end
        S_SHTDN: begin
          if (cnt_reg == CW'(SHTDN_CYC - 1)) begin
            state_next = S_U2U3;
            cnt_next = '0;
          end
        end
        S_DISC: begin
          if (rx_s) begin
            state_next = S_U0;
            term_next = 1'b1;
            idle_next = 1'b0;
            cnt_next = '0;
          end else if (cnt_reg == CW'(RXDET_CYC - 1)) begin
            rxdet_next = 1'b1;
            cnt_next = '0;
          end
        end
        S_U0: begin
          if (!rx_s) begin
            state_next = S_DISC;
            term_next = 1'b0;
            idle_next = 1'b1;
            cnt_next = '0;
          end else if (!idle_s) begin
            cnt_next = '0;
          end else if (cnt_reg == CW'(IDLE_ENTRY - 1)) begin
            state_next = S_U1;
            idle_next = 1'b1;
            cnt_next = '0;
          end
        end
        S_U1, S_U2U3: begin
          cnt_next = '0;
          if (!rx_s) begin
            state_next = S_DISC;
            term_next = 1'b0;
          end else if (!idle_s) begin
            state_next = S_WAKE;
            lim_next = (state_reg == S_U1) ? CW'(U1_EXIT) :
              CW'(U2_EXIT);
          end else if (state_reg == S_U1) begin
            cnt_next = cnt_inc;
            if (cnt_reg == CW'(U1U2_CYC - 1)) begin
              state_next = S_U2U3;
              cnt_next = '0;
            end
          end
        end
        S_WAKE: begin
          if (cnt_reg == lim_reg - CW'(1)) begin
            state_next = S_U0;
            idle_next = 1'b0;
            cnt_next = '0;
          end
        end
        default: begin
          state_next = S_POR;
          cnt_next = '0;
        end
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= S_POR;
      cnt_reg <= '0;
      lim_reg <= '0;
      o_tx_elec_idle <= 1'b1;
      o_rx_term_en <= 1'b0;
      o_rxdet_start <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      lim_reg <= lim_next;
      o_tx_elec_idle <= idle_next;
      o_rx_term_en <= term_next;
      o_rxdet_start <= rxdet_next;
    end
  end

  // ==========================================================
  // lane, switch and equalizer outputs
  wire [5:0] eq_src_w = ctrl_reg ? eqprog_reg : eq_pin_s;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_active <= 1'b0;
      o_usb_lanes_en <= 1'b0;
      o_dp_lane_en <= 4'h0;
      o_flip <= 1'b0;
      o_aux_switch_closed <= 1'b0;
      o_eq_en <= 1'b0;
      o_eq_gain <= 6'h00;
    end else begin
      o_active <= state_next != S_POR;
      o_usb_lanes_en <= usb_lanes_w;
      o_dp_lane_en <= dp_mask_w;
      o_flip <= flip_s;
      o_aux_switch_closed <= disp_db;
      o_eq_en <= !lfps_s;
      o_eq_gain <= eq_src_w;
    end
  end

  // ==========================================================
  // checks
  aux_close_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(disp_db) |=> o_aux_switch_closed)
    else $error("aux switch did not close");
  aux_open_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(disp_db) |=> !o_aux_switch_closed)
    else $error("aux switch did not open");
  deb_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(disp_db) |-> $past(deb_cnt_reg[1]) == CW'(DEB_CYC - 1))
    else $error("display enable fell before debounce");
  deb_restart_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    disp_s |=> disp_db && deb_cnt_reg[1] == '0)
    else $error("debounce not restarted");
  rxdet_gap_a: assert property (@(posedge i_clk) disable iff (i_reset)
    state_reg == S_DISC |-> cnt_reg < CW'(RXDET_CYC))
    else $error("receiver detect interval too long");
  term_en_a: assert property (@(posedge i_clk) disable iff (i_reset)
    state_reg == S_DISC && rx_s && usb_eff |=> state_reg == S_U0
    && o_rx_term_en && !o_tx_elec_idle)
    else $error("termination not enabled on detect");
  idle_entry_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_reg == S_U0 && rx_s && idle_s && usb_eff |=> o_tx_elec_idle)
    else $error("no electrical idle after U0");
  u1_exit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    state_reg == S_U1 && rx_s && !idle_s && usb_eff ##1 usb_eff
    |=> state_reg == S_U0 && !o_tx_elec_idle)
    else $error("U1 exit too slow");
  u2_exit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    state_reg == S_WAKE |-> cnt_reg < CW'(U2_EXIT))
    else $error("U2 exit too slow");
  shtdn_exit_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_reg == S_SHTDN |-> cnt_reg < CW'(SHTDN_CYC))
    else $error("shutdown exit too slow");
  eq_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
    lfps_s |=> !o_eq_en)
    else $error("equalizer on during lfps");
  por_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !o_active |-> $past(cnt_reg) < CW'(POR_CYC))
    else $error("device not active in time");
  mode_a: assert property (@(posedge i_clk) disable iff (i_reset)
    disp_db && !usb_eff && hpd_db |=> o_dp_lane_en == 4'hF
    && !o_usb_lanes_en)
    else $error("four lane mode not decoded");
endmodule

// >>> logic/rlsc_pkg.sv
/*
  Types of the redriver link state control.
  Assumes rlsc_defines.svh for all numeric constants.
*/
package rlsc_pkg;
  typedef enum logic [2:0] {
    S_POR, S_SHTDN, S_DISC, S_U0, S_U1, S_U2U3, S_WAKE
  } rlsc_state_t;
  typedef enum logic [1:0] {
    M_OFF, M_USB, M_DP4, M_USB_DP2
  } rlsc_mode_t;
endpackage

// >>> verif/rlsc_link_ctrl_bench.sv
/*
  Bench of the redriver link state control with a pin and APB driver.
  Assumes the policy controller model owns both enable pins.
*/
`timescale 1ns/1ps
module rlsc_link_ctrl_bench import rlsc_pkg::*;;
  localparam int DEB_C = 20;
  localparam int RX_C = 40;
  localparam int SHT_C = 30;
  localparam int U12_C = 50;
  localparam int POR_C = 50000;
  logic clk, rst, dpin, upin, flip, hpd, rxd, eidle, lfps;
  logic [1:0] eqh, eqs, eqd;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic act, rxs, term, idle, usbl, flp, aux, eqen;
  logic [3:0] dpl;
  logic [5:0] gain;
  int failures = 0;
  int num_checks = 0;

  // ==========================================================
  // design and partner
  rlsc_link_ctrl #(.DEB_CYC(DEB_C), .RXDET_CYC(RX_C), .SHTDN_CYC(SHT_C),
    .U1U2_CYC(U12_C)) uut (
    .i_clk(clk), .i_reset(rst), .i_display_enable_pin(dpin),
    .i_usb_enable_pin(upin), .i_flip_pin(flip), .i_hot_plug_input(hpd),
    .i_rx_detected(rxd), .i_elec_idle(eidle), .i_lfps_detected(lfps),
    .i_host_path_eq_select(eqh), .i_superspeed_path_eq_select(eqs),
    .i_display_path_eq_select(eqd), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_active(act), .o_rxdet_start(rxs), .o_rx_term_en(term),
    .o_tx_elec_idle(idle), .o_usb_lanes_en(usbl), .o_dp_lane_en(dpl),
    .o_flip(flp), .o_aux_switch_closed(aux), .o_eq_en(eqen),
    .o_eq_gain(gain));
  rlsc_pd_model #(.OVL_CYC(200)) pd (
    .i_clk(clk), .o_disp_pin(dpin), .o_usb_pin(upin));

  // ==========================================================
  // reference model and helpers
  function automatic logic [4:0] lanes(input logic d, input logic u);
    lanes = {u, d ? (u ? 4'h3 : 4'hF) : 4'h0};
  endfunction

  function automatic logic sig(input int k);
    case (k)
      0: sig = aux;
      1: sig = idle;
      2: sig = term;
      3: sig = act;
      4: sig = eqen;
      default: sig = rxs;
    endcase
  endfunction

  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic wait_val(input int k, input logic v, input int lim,
    output int n);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(sig(k), v, "output did not settle in time");
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    chk(pready, 1'b1, "no apb answer");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // ==========================================================
  // clock, watchdog and tests
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end

  initial begin
    int n;
    logic [31:0] r;
    logic e;
    logic [5:0] g;
    {rst, flip, hpd, rxd, eidle, lfps} = 6'h28;
    {eqh, eqs, eqd, psel, penable, pwrite, paddr, pwdata} = '0;
    n = $urandom(32'hF136);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk({idle, act, term, aux}, 4'h8, "reset levels wrong");
    wait_val(3, 1'b1, POR_C, n);
    wait_val(5, 1'b1, RX_C + 2, n);
    @(posedge clk);
    wait_val(5, 1'b1, RX_C + 2, n);
    chk(n < RX_C, 1'b1, "detect interval too long");
    rxd <= 1'b1;
    wait_val(2, 1'b1, 5, n);
    wait_val(1, 1'b0, 5, n);
    eidle <= 1'b1;
    wait_val(1, 1'b1, 5, n);
    eidle <= 1'b0;
    wait_val(1, 1'b0, 6, n);
    eidle <= 1'b1;
    repeat (U12_C + 20) @(posedge clk);
    eidle <= 1'b0;
    wait_val(1, 1'b0, 520, n);
    chk(n >= 490, 1'b1, "low power exit too early");
    lfps <= 1'b1;
    wait_val(4, 1'b0, 5, n);
    lfps <= 1'b0;
    wait_val(4, 1'b1, 5, n);
    repeat (4) begin
      {eqh, eqs, eqd} <= 6'($urandom);
      repeat (4) @(posedge clk);
      chk(gain, {eqh, eqs, eqd}, "eq pins not applied");
    end
    g = 6'($urandom);
    apb(1'b1, 12'h004, {26'h0, g}, r, e);
    apb(1'b1, 12'h000, 32'h1, r, e);
    repeat (4) @(posedge clk);
    chk(gain, g, "programmed eq not applied");
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk(r, {26'h0, g}, "eq register readback");
    apb(1'b0, 12'h0FC, 32'h0, r, e);
    chk(r, 32'h0, "unmapped read data");
    chk(e, 1'b1, "unmapped access");
    apb(1'b1, 12'h000, 32'h0, r, e);
    chk({usbl, dpl}, 5'h10, "usb-only default lost");
    pd.pulse_usb();
    repeat (8) @(posedge clk);
    chk({usbl, dpl}, 5'h00, "power down lanes");
    eidle <= 1'b1;
    pd.set_mode(1'b0, 1'b1);
    n = 1;
    do begin
      apb(1'b0, 12'h008, 32'h0, r, e);
      n += 4;
    end while (r[2:0] !== S_U2U3 && n < SHT_C + 40);
    chk(r[2:0], S_U2U3, "shutdown exit state");
    eidle <= 1'b0;
    for (int c = 1; c < 8; c++) begin
      if (c[1:0] != 2'h0) begin
        flip <= c[2];
        pd.set_mode(c[1], c[0]);
        repeat (DEB_C + 10) @(posedge clk);
        chk({usbl, dpl, flp}, {lanes(c[1], c[0]), c[2]},
          "lane mode");
      end
    end
    chk(aux, 1'b1, "aux open in display mode");
    pd.glitch(DEB_C / 2);
    repeat (DEB_C + 10) @(posedge clk);
    chk({aux, dpl}, 5'h13, "glitch not filtered");
    pd.set_mode(1'b0, 1'b1);
    wait_val(0, 1'b0, DEB_C + 380, n);
    chk(n >= DEB_C, 1'b1, "aux opened before debounce");
    pd.set_mode(1'b1, 1'b1);
    wait_val(0, 1'b1, 150, n);
    repeat (DEB_C + 10) @(posedge clk);
    hpd <= 1'b0;
    repeat (DEB_C - 5) @(posedge clk);
    chk(dpl, 4'h3, "hot plug low taken early");
    repeat (15) @(posedge clk);
    chk(dpl, 4'h0, "hot plug low not taken");
    give_verdict();
  end
endmodule

// >>> verif/rlsc_pd_model.sv
/*
  Policy controller model: drives the display and usb enable pins.
  Assumes its tasks are called from one bench process just after a
  rising edge of i_clk.
*/
`timescale 1ns/1ps
module rlsc_pd_model #(
  parameter int OVL_CYC = 200
) (
  input wire logic i_clk,
  output logic o_disp_pin,
  output logic o_usb_pin
);
  // ==========================================================
  // pin control
  initial begin
    o_disp_pin = 1'b0;
    o_usb_pin = 1'b0;
  end

  // both pins flip: hold both high first, 4 us at 50 MHz
  task automatic set_mode(input logic d, input logic u);
    if (d != o_disp_pin && u != o_usb_pin) begin
      o_disp_pin <= 1'b1;
      o_usb_pin <= 1'b1;
      repeat (OVL_CYC) @(posedge i_clk);
    end
    o_disp_pin <= d;
    o_usb_pin <= u;
    @(posedge i_clk);
  endtask

  // leave the usb-only default
  task automatic pulse_usb();
    o_usb_pin <= 1'b1;
    repeat (5) @(posedge i_clk);
    o_usb_pin <= 1'b0;
    @(posedge i_clk);
  endtask

  // short low on the display pin
  task automatic glitch(input int n);
    o_disp_pin <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_disp_pin <= 1'b1;
    @(posedge i_clk);
  endtask
endmodule
